/* File: core/gp_timer_pkg.sv */
/*
  Package for the general-purpose timer block: register offsets, field layouts,
  reset values, mode and half encodings, and the packed carrier structs.
  Assumes a single 50 MHz system clock and a synchronous active-high reset.
*/
package gp_timer_pkg;

  // Register word offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] CTL_OFF = 8'h04;
  localparam logic [7:0] MODE_A_OFF = 8'h08;
  localparam logic [7:0] MODE_B_OFF = 8'h0C;
  localparam logic [7:0] MASK_OFF = 8'h10;
  localparam logic [7:0] RAW_OFF = 8'h14;
  localparam logic [7:0] MSTAT_OFF = 8'h18;
  localparam logic [7:0] CLR_OFF = 8'h1C;
  localparam logic [7:0] LOAD_A_OFF = 8'h20;
  localparam logic [7:0] LOAD_B_OFF = 8'h24;
  localparam logic [7:0] MATCH_A_OFF = 8'h28;
  localparam logic [7:0] MATCH_B_OFF = 8'h2C;
  localparam logic [7:0] PRE_A_OFF = 8'h30;
  localparam logic [7:0] PRE_B_OFF = 8'h34;
  localparam logic [7:0] PMATCH_A_OFF = 8'h38;
  localparam logic [7:0] PMATCH_B_OFF = 8'h3C;
  localparam logic [7:0] VAL_A_OFF = 8'h48;
  localparam logic [7:0] VAL_B_OFF = 8'h4C;
  localparam logic [7:0] SYNC_OFF = 8'h50;
  localparam logic [7:0] ADDR_MASK = 8'hFC;

  // Control register bits
  localparam int CTL_EN_A = 0;
  localparam int CTL_EN_B = 1;
  localparam int CTL_RTC_EN = 2;
  localparam int CTL_PWM_INV_A = 3;
  localparam int CTL_PWM_INV_B = 4;

  // Configuration register: bit 0 selects full-width operation
  localparam int CFG_FULL = 0;

  // Mode register: bits 1:0 mode, bit 2 count up, bit 3 match interrupt enable
  localparam int MODE_UP = 2;
  localparam int MODE_MIE = 3;

  // Status bit positions (timeout, capture match, capture event, rtc, dma per half)
  localparam int ST_TIMEOUT_A = 0;
  localparam int ST_CMATCH_A = 1;
  localparam int ST_CEVENT_A = 2;
  localparam int ST_RTC = 3;
  localparam int ST_MMATCH_A = 4;
  localparam int ST_DMA_A = 5;
  localparam int ST_TIMEOUT_B = 8;
  localparam int ST_CMATCH_B = 9;
  localparam int ST_CEVENT_B = 10;
  localparam int ST_MMATCH_B = 11;
  localparam int ST_DMA_B = 13;
  localparam int ST_W = 14;

  // Synchronisation selection: 12 standard half bits then 12 wide half bits
  localparam int SYNC_W = 24;
  localparam int SYNC_WIDE_BASE = 12;

  // Variant widths: wide (32/64) timer halves are 32 bits, prescaler 16 bits
  localparam int HALF_W = 32;
  localparam int PRE_W = 16;
  localparam int STD_PRE_W = 8;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_LOAD = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    MODE_ONESHOT,
    MODE_PERIODIC,
    MODE_CAPTURE,
    MODE_RTC_PWM
  } tmode_t;

  // Per-half configuration carrier
  typedef struct packed {
    logic mie;
    logic up;
    tmode_t mode;
  } half_cfg_t;

  // Register bus request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage : gp_timer_pkg

/* File: core/gp_timer_load_match_prescale.sv */
/*
  One timer module with halves A and B, chainable into a 64-bit full-width timer.
  Registers sit on a plain strobe port; read data appear one cycle after the read strobe.
  Assumes software configures before enabling and uses only the A half when full width.
  The sync_sel input carries the synchronisation vector issued through the first module;
  this instance picks its own two bits by the SYNC_INDEX parameter.
*/
// Summary of operation
// - Writing a half load while counting loads the counter at once.
// - Writing either word of the 64-bit load while counting loads that counter word at once.
// - Halves work alone or chained; chained load and match span 64 bits.
// - Capture count mode raises match status when counter equals match.
// - PWM output toggles where counter crosses match in each period.
// - Periodic and one-shot raise match status when enabled and reached.
// - Prescaler works only in half-width mode, ignored when full width.
// - Prescaler is low bits counting down periodic/one-shot, else high bits.
// - Prescale value field holds 0 to 65535 in this wide variant.
// - Prescale match extends match in the same position as prescaler.
// - Prescale match field holds 0 to 65535 in this wide variant.
// - RTC mode counts only while RTC enable is set.
// - RTC enable does nothing outside RTC mode.
// - Sync request comes via first module, one bit per half, one event.
// - In half-width mode each half is selected for sync independently.
// - In full-width mode only A syncs; the B selection is ignored.
// - Events reach the interrupt only when masked in; raw stays readable.
`timescale 1ns/1ns
module gp_timer_load_match_prescale
  import gp_timer_pkg::*;
#(
  parameter int SYNC_INDEX = 0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [SYNC_W-1:0] sync_sel,
  input wire logic sync_stb,
  output logic [31:0] rdata,
  output logic irq,
  output logic pwm_a,
  output logic pwm_b,
  output logic [SYNC_W-1:0] sync_out,
  output logic sync_out_stb
);

  logic cfg_full_reg;
  logic [4:0] ctl_reg;
  half_cfg_t hcfg_reg [2];
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] raw_reg;
  logic [HALF_W-1:0] load_reg [2];
  logic [HALF_W-1:0] match_reg [2];
  logic [PRE_W-1:0] pre_reg [2];
  logic [PRE_W-1:0] pmatch_reg [2];
  logic [HALF_W-1:0] cnt_reg [2];
  logic [PRE_W-1:0] pcnt_reg [2];
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [1:0] pwm_reg;
  logic [SYNC_W-1:0] sync_out_reg;
  logic sync_out_stb_reg;

  bus_req_t req;
  assign req = '{wr: wr_stb, rd: rd_stb, addr: addr & ADDR_MASK, wdata: wdata};

  // Write decode
  wire w_cfg = req.wr && req.addr == CFG_OFF;
  wire w_ctl = req.wr && req.addr == CTL_OFF;
  wire w_mask = req.wr && req.addr == MASK_OFF;
  wire w_clr = req.wr && req.addr == CLR_OFF;
  wire w_sync = req.wr && req.addr == SYNC_OFF;
  wire [1:0] w_mode = {req.wr && req.addr == MODE_B_OFF, req.wr && req.addr == MODE_A_OFF};
  wire [1:0] w_load = {req.wr && req.addr == LOAD_B_OFF, req.wr && req.addr == LOAD_A_OFF};
  wire [1:0] w_match = {req.wr && req.addr == MATCH_B_OFF, req.wr && req.addr == MATCH_A_OFF};
  wire [1:0] w_pre = {req.wr && req.addr == PRE_B_OFF, req.wr && req.addr == PRE_A_OFF};
  wire [1:0] w_pmatch = {req.wr && req.addr == PMATCH_B_OFF, req.wr && req.addr == PMATCH_A_OFF};

  // Sync selection for this module; full width drops the B bit
  wire [4:0] sbase = SYNC_INDEX[5] ? 5'(SYNC_WIDE_BASE + 2 * (SYNC_INDEX % 8)) : 5'(2 * SYNC_INDEX);
  wire sync_hit_a = sync_stb && sync_sel[sbase];
  wire sync_hit_b = sync_stb && sync_sel[sbase + 5'd1] && !cfg_full_reg;
  wire [1:0] sync_hit = {sync_hit_b, sync_hit_a};

  // 64-bit chained counter view: A holds low word, B high word
  wire [63:0] cnt64 = {cnt_reg[1], cnt_reg[0]};
  wire [63:0] load64 = {load_reg[1], load_reg[0]};
  wire [63:0] match64 = {match_reg[1], match_reg[0]};
  wire full_up = hcfg_reg[0].up;
  wire full_run = ctl_reg[CTL_EN_A] && (hcfg_reg[0].mode != MODE_RTC_PWM || ctl_reg[CTL_RTC_EN]);
  wire full_end = full_up ? (cnt64 == load64) : (cnt64 == 64'h0);
  wire full_hit = full_run && cnt64 == match64;
  wire [63:0] full_next = full_end ? (full_up ? 64'h0 : load64) : (full_up ? cnt64 + 64'h1 : cnt64 - 64'h1);
  wire full_stop = full_end && hcfg_reg[0].mode == MODE_ONESHOT;

  // Per-half 48-bit extended count, prescaler placed by mode
  logic [1:0] half_run;
  logic [1:0] half_end;
  logic [1:0] half_hit;
  logic [1:0] pre_low;
  logic [47:0] ext_cnt [2];
  logic [47:0] ext_load [2];
  logic [47:0] ext_match [2];
  logic [47:0] ext_next [2];
  logic [1:0] pwm_next;

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      // Prescaler low bits only for down-counting periodic or one-shot
      assign pre_low[h] = !hcfg_reg[h].up &&
                          (hcfg_reg[h].mode == MODE_ONESHOT || hcfg_reg[h].mode == MODE_PERIODIC);
      assign ext_cnt[h] = pre_low[h] ? {cnt_reg[h], pcnt_reg[h]} : {pcnt_reg[h], cnt_reg[h]};
      assign ext_load[h] = pre_low[h] ? {load_reg[h], pre_reg[h]} : {pre_reg[h], load_reg[h]};
      assign ext_match[h] = pre_low[h] ? {match_reg[h], pmatch_reg[h]} : {pmatch_reg[h], match_reg[h]};
      // Mode 3 of a half is PWM, so the RTC enable has no say here
      assign half_run[h] = ctl_reg[h];
      assign half_end[h] = hcfg_reg[h].up ? (ext_cnt[h] == ext_load[h]) : (ext_cnt[h] == 48'h0);
      assign half_hit[h] = half_run[h] && ext_cnt[h] == ext_match[h];
      // Low-bit prescaler wraps back to its setting in the same step as the counter steps down once
      assign ext_next[h] = half_end[h] ? (hcfg_reg[h].up ? 48'h0 : ext_load[h]) :
                           (hcfg_reg[h].up ? ext_cnt[h] + 48'h1 :
                           ((pre_low[h] && pcnt_reg[h] == 16'h0) ? {cnt_reg[h] - 32'h1, pre_reg[h]} :
                           ext_cnt[h] - 48'h1));
      // PWM: high from period start until the count crosses match; invert on the way out
      assign pwm_next[h] = (half_end[h] ? 1'b1 : (half_hit[h] ? 1'b0 : (pwm_reg[h] ^ ctl_reg[CTL_PWM_INV_A + h])))
                           ^ ctl_reg[CTL_PWM_INV_A + h];
    end
  endgenerate

  // Event sources per half
  wire [1:0] ev_timeout = cfg_full_reg ? {1'b0, full_run && full_end} : (half_run & half_end);
  wire [1:0] hit_any = cfg_full_reg ? {1'b0, full_hit} : half_hit;
  wire [1:0] ev_cmatch = {hit_any[1] && hcfg_reg[1].mode == MODE_CAPTURE, hit_any[0] && hcfg_reg[0].mode == MODE_CAPTURE};
  wire [1:0] ev_mmatch = {hit_any[1] && hcfg_reg[1].mie && hcfg_reg[1].mode[1] == 1'b0,
                          hit_any[0] && hcfg_reg[0].mie && hcfg_reg[0].mode[1] == 1'b0};
  wire ev_rtc = cfg_full_reg && hit_any[0] && hcfg_reg[0].mode == MODE_RTC_PWM && ctl_reg[CTL_RTC_EN];
  logic [ST_W-1:0] ev_vec;
  always_comb begin
    ev_vec = '0;
    ev_vec[ST_TIMEOUT_A] = ev_timeout[0];
    ev_vec[ST_CMATCH_A] = ev_cmatch[0];
    ev_vec[ST_RTC] = ev_rtc;
    ev_vec[ST_MMATCH_A] = ev_mmatch[0];
    ev_vec[ST_TIMEOUT_B] = ev_timeout[1];
    ev_vec[ST_CMATCH_B] = ev_cmatch[1];
    ev_vec[ST_MMATCH_B] = ev_mmatch[1];
  end
  // Set wins over a software clear in the same cycle
  wire [ST_W-1:0] raw_next = (raw_reg & ~(w_clr ? req.wdata[ST_W-1:0] : '0)) | ev_vec;
  wire [ST_W-1:0] masked = raw_reg & mask_reg;

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (req.addr)
      CFG_OFF: rd_mux = {31'h0, cfg_full_reg};
      CTL_OFF: rd_mux = {27'h0, ctl_reg};
      MODE_A_OFF: rd_mux = {28'h0, hcfg_reg[0]};
      MODE_B_OFF: rd_mux = {28'h0, hcfg_reg[1]};
      MASK_OFF: rd_mux = {18'h0, mask_reg};
      RAW_OFF: rd_mux = {18'h0, raw_reg};
      MSTAT_OFF: rd_mux = {18'h0, masked};
      LOAD_A_OFF: rd_mux = load_reg[0];
      LOAD_B_OFF: rd_mux = load_reg[1];
      MATCH_A_OFF: rd_mux = match_reg[0];
      MATCH_B_OFF: rd_mux = match_reg[1];
      PRE_A_OFF: rd_mux = {16'h0, pre_reg[0]};
      PRE_B_OFF: rd_mux = {16'h0, pre_reg[1]};
      PMATCH_A_OFF: rd_mux = {16'h0, pmatch_reg[0]};
      PMATCH_B_OFF: rd_mux = {16'h0, pmatch_reg[1]};
      VAL_A_OFF: rd_mux = cnt_reg[0];
      VAL_B_OFF: rd_mux = cnt_reg[1];
      default: rd_mux = RST_ZERO;
    endcase
  end

  // Configuration and status registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_full_reg <= 1'b0;
      ctl_reg <= '0;
      mask_reg <= '0;
      raw_reg <= '0;
      rdata_reg <= RST_ZERO;
      irq_reg <= 1'b0;
      sync_out_reg <= '0;
      sync_out_stb_reg <= 1'b0;
    end else begin
      if (w_cfg) cfg_full_reg <= req.wdata[CFG_FULL];
      if (w_ctl) ctl_reg <= req.wdata[4:0];
      if (w_mask) mask_reg <= req.wdata[ST_W-1:0];
      // One-shot stop clears the enable after its timeout
      if (!w_ctl && cfg_full_reg && full_run && full_stop) ctl_reg[CTL_EN_A] <= 1'b0;
      if (!w_ctl && !cfg_full_reg) begin
        if (half_run[0] && half_end[0] && hcfg_reg[0].mode == MODE_ONESHOT) ctl_reg[CTL_EN_A] <= 1'b0;
        if (half_run[1] && half_end[1] && hcfg_reg[1].mode == MODE_ONESHOT) ctl_reg[CTL_EN_B] <= 1'b0;
      end
      raw_reg <= raw_next;
      irq_reg <= |(raw_next & mask_reg);
      rdata_reg <= req.rd ? rd_mux : RST_ZERO;
      sync_out_reg <= w_sync ? req.wdata[SYNC_W-1:0] : '0;
      sync_out_stb_reg <= w_sync;
    end
  end

  // Settings and counters per half
  generate
    for (h = 0; h < 2; h++) begin : g_regs
      always_ff @(posedge clk) begin
        if (srst) begin
          hcfg_reg[h] <= '0;
          load_reg[h] <= RST_LOAD;
          match_reg[h] <= RST_LOAD;
          pre_reg[h] <= '0;
          pmatch_reg[h] <= '0;
          cnt_reg[h] <= RST_LOAD;
          pcnt_reg[h] <= '0;
          pwm_reg[h] <= 1'b0;
        end else begin
          if (w_mode[h]) hcfg_reg[h] <= req.wdata[3:0];
          if (w_load[h]) load_reg[h] <= req.wdata;
          if (w_match[h]) match_reg[h] <= req.wdata;
          if (w_pre[h]) pre_reg[h] <= req.wdata[PRE_W-1:0];
          if (w_pmatch[h]) pmatch_reg[h] <= req.wdata[PRE_W-1:0];
          pwm_reg[h] <= (half_run[h] && !cfg_full_reg) ? pwm_next[h] : pwm_reg[h];
          if (cfg_full_reg) begin
            // Chained: counter pair moves as one 64-bit value, prescaler idle
            pcnt_reg[h] <= '0;
            if (w_load[h] || sync_hit_a) begin
              cnt_reg[h] <= w_load[h] ? req.wdata : load_reg[h];
            end else if (full_run) begin
              cnt_reg[h] <= full_next[HALF_W*h +: HALF_W];
            end
          end else if (w_load[h] || sync_hit[h]) begin
            // Immediate reload on load write or sync event
            cnt_reg[h] <= w_load[h] ? req.wdata : load_reg[h];
            pcnt_reg[h] <= pre_reg[h];
          end else if (half_run[h]) begin
            cnt_reg[h] <= pre_low[h] ? ext_next[h][47:16] : ext_next[h][31:0];
            pcnt_reg[h] <= pre_low[h] ? ext_next[h][15:0] : ext_next[h][47:32];
          end
        end
      end
    end
  endgenerate

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign pwm_a = pwm_reg[0];
  assign pwm_b = pwm_reg[1];
  assign sync_out = sync_out_reg;
  assign sync_out_stb = sync_out_stb_reg;

  // Load write lands in the counter on the very next edge
  load_now_a: assert property (@(posedge clk) disable iff (srst)
    (w_load[0] && !cfg_full_reg) |=> cnt_reg[0] == $past(wdata))
    else $error("half A load not taken at once");

  full_sync_a: assert property (@(posedge clk) disable iff (srst)
    (sync_stb && cfg_full_reg && !w_load[1] && !sync_hit_a && !full_run) |=> $stable(cnt_reg[1]))
    else $error("B half moved on sync in full width");

  rtc_hold_a: assert property (@(posedge clk) disable iff (srst)
    (hcfg_reg[0].mode == MODE_RTC_PWM && !ctl_reg[CTL_RTC_EN] && cfg_full_reg && !w_load[0] && !sync_hit_a)
    |=> $stable(cnt_reg[0]))
    else $error("RTC timer counted while disabled");

  // Sync event puts the load value into a selected half
  sync_load_a: assert property (@(posedge clk) disable iff (srst)
    (sync_hit_a && !w_load[0] && !cfg_full_reg) |=> cnt_reg[0] == $past(load_reg[0]))
    else $error("half A not reloaded on sync");

  irq_mask_a: assert property (@(posedge clk) disable iff (srst)
    (mask_reg == '0 && !w_mask) |=> !irq_reg)
    else $error("interrupt raised with all masked");

  ext_pre_a: assert property (@(posedge clk) disable iff (srst)
    cfg_full_reg |=> pcnt_reg[0] == '0)
    else $error("prescaler active in full width");

endmodule : gp_timer_load_match_prescale

/* File: bench/tb.sv */
/*
  Self-checking bench for the timer block: reset values, readback, load while counting,
  prescaler, match status, PWM, RTC enable, mask gating and counter synchronisation.
  Assumes the design's register map and a 50 MHz clock; the bench drives sync inputs itself.
*/
`timescale 1ns/1ns
module tb;
  import gp_timer_pkg::*;
  localparam int SI = 0;
  logic clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, sync_stb = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [SYNC_W-1:0] sync_sel = '0;
  logic [31:0] rdata;
  logic irq, pwm_a, pwm_b, sync_out_stb;
  logic [SYNC_W-1:0] sync_out;
  int err_count = 0, n_compared = 0, cycles = 0;

  gp_timer_load_match_prescale #(.SYNC_INDEX(SI)) DUT (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .sync_sel(sync_sel), .sync_stb(sync_stb),
    .rdata(rdata), .irq(irq), .pwm_a(pwm_a), .pwm_b(pwm_b), .sync_out(sync_out),
    .sync_out_stb(sync_out_stb));

  // Clock and hang guard
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic restart();
    @(posedge clk);
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
  endtask : restart

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic pulse_sync(input logic [SYNC_W-1:0] s);
    @(posedge clk);
    sync_stb <= 1'b1;
    sync_sel <= s;
    @(posedge clk);
    sync_stb <= 1'b0;
  endtask : pulse_sync

  // Reset values, an unmapped read and readback of written settings
  task automatic t_readback();
    logic [31:0] v;
    restart();
    rd(LOAD_A_OFF, v); chk("load reset", v, RST_LOAD);
    rd(PRE_A_OFF, v); chk("prescale reset", v, RST_ZERO);
    rd(8'h44, v); chk("unmapped read", v, 32'h0);
    #20 chk("rdata idle", rdata, 32'h0);
    wr(LOAD_B_OFF, 32'h1234_5678); wr(MATCH_B_OFF, 32'h0000_0ABC);
    wr(PRE_B_OFF, 32'h0000_FFFF); wr(PMATCH_B_OFF, 32'h0000_8001);
    rd(LOAD_B_OFF, v); chk("load readback", v, 32'h1234_5678);
    rd(MATCH_B_OFF, v); chk("match readback", v, 32'h0000_0ABC);
    rd(PRE_B_OFF, v); chk("prescale max", v, 32'h0000_FFFF);
    rd(PMATCH_B_OFF, v); chk("pmatch readback", v, 32'h0000_8001);
  endtask : t_readback

  // Load written while counting goes into the counter at once, half and full width
  task automatic t_load_now();
    logic [31:0] v, h;
    restart();
    wr(MODE_A_OFF, 32'h1);
    wr(CTL_OFF, 32'h1);
    repeat (50) @(posedge clk);
    wr(LOAD_A_OFF, 32'h0000_0500);
    rd(VAL_A_OFF, v); chk("half load now", {31'h0, v <= 32'h500 && v >= 32'h4F8}, 32'h1);
    restart();
    wr(CFG_OFF, 32'h1); wr(MODE_A_OFF, 32'h1); wr(CTL_OFF, 32'h1);
    repeat (50) @(posedge clk);
    wr(LOAD_B_OFF, 32'h0000_00A5);
    wr(LOAD_A_OFF, 32'h8000_0000);
    rd(VAL_B_OFF, h); chk("wide high word", h, 32'h0000_00A5);
    rd(VAL_A_OFF, v); chk("wide low word", {31'h0, v <= 32'h8000_0000 && v >= 32'h7FFF_FFF0}, 32'h1);
  endtask : t_load_now

  // Prescaler slows a half but is ignored when full width
  task automatic t_prescale();
    logic [31:0] v;
    restart();
    wr(MODE_A_OFF, 32'h1); wr(PRE_A_OFF, 32'h3);
    wr(LOAD_A_OFF, 32'h0000_1000); wr(CTL_OFF, 32'h1);
    repeat (40) @(posedge clk);
    rd(VAL_A_OFF, v); chk("half prescaled", {31'h0, v <= 32'hFF8 && v >= 32'hFF2}, 32'h1);
    restart();
    wr(CFG_OFF, 32'h1); wr(MODE_A_OFF, 32'h1); wr(PRE_A_OFF, 32'h3);
    wr(LOAD_B_OFF, 32'h0); wr(LOAD_A_OFF, 32'h0000_1000); wr(CTL_OFF, 32'h1);
    repeat (40) @(posedge clk);
    rd(VAL_A_OFF, v); chk("full no prescale", {31'h0, v <= 32'hFD8 && v >= 32'hFC8}, 32'h1);
  endtask : t_prescale

  // Match status in periodic mode, and the mask gating the interrupt line
  task automatic t_match_irq();
    logic [31:0] v;
    restart();
    wr(MODE_A_OFF, 32'h9); wr(LOAD_A_OFF, 32'h64); wr(MATCH_A_OFF, 32'h32);
    wr(PMATCH_A_OFF, 32'h0); wr(CTL_OFF, 32'h1);
    repeat (80) @(posedge clk);
    rd(RAW_OFF, v); chk("periodic match raw", {31'h0, v[ST_MMATCH_A]}, 32'h1);
    chk("irq masked off", {31'h0, irq}, 32'h0);
    wr(MASK_OFF, 32'h1 << ST_MMATCH_A);
    repeat (2) @(posedge clk);
    #1 chk("irq masked in", {31'h0, irq}, 32'h1);
    wr(MASK_OFF, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq masked again", {31'h0, irq}, 32'h0);
    rd(RAW_OFF, v); chk("raw still set", {31'h0, v[ST_MMATCH_A]}, 32'h1);
    wr(MODE_B_OFF, 32'h2); wr(LOAD_B_OFF, 32'h64); wr(MATCH_B_OFF, 32'h32); wr(CTL_OFF, 32'h2);
    repeat (80) @(posedge clk);
    rd(RAW_OFF, v); chk("capture match raw", {31'h0, v[ST_CMATCH_B]}, 32'h1);
  endtask : t_match_irq

  // PWM output follows the match within each load period
  task automatic t_pwm();
    int highs;
    restart();
    highs = 0;
    wr(MODE_A_OFF, 32'h3); wr(LOAD_A_OFF, 32'h14); wr(MATCH_A_OFF, 32'hA); wr(CTL_OFF, 32'h1);
    repeat (10) @(posedge clk);
    repeat (42) begin
      @(posedge clk);
      #1 if (pwm_a === 1'b1) highs++;
    end
    chk("pwm duty", {31'h0, highs >= 16 && highs <= 24}, 32'h1);
  endtask : t_pwm

  // RTC enable starts and stops counting in RTC mode only
  task automatic t_rtc();
    logic [31:0] v1, v2;
    restart();
    wr(CFG_OFF, 32'h1); wr(MODE_A_OFF, 32'h3); wr(CTL_OFF, 32'h1);
    rd(VAL_A_OFF, v1); repeat (10) @(posedge clk); rd(VAL_A_OFF, v2);
    chk("rtc stopped", v2, v1);
    wr(CTL_OFF, 32'h5);
    rd(VAL_A_OFF, v1); repeat (10) @(posedge clk); rd(VAL_A_OFF, v2);
    chk("rtc running", {31'h0, v2 !== v1}, 32'h1);
    restart();
    wr(MODE_A_OFF, 32'h1); wr(CTL_OFF, 32'h5);
    rd(VAL_A_OFF, v1); repeat (10) @(posedge clk); rd(VAL_A_OFF, v2);
    chk("rtc bit ignored", {31'h0, v1 - v2 >= 32'hA && v1 - v2 <= 32'hE}, 32'h1);
  endtask : t_rtc

  // Sync request echo and selective reload of halves
  task automatic t_sync();
    logic [31:0] va, vb;
    logic [SYNC_W-1:0] s;
    restart();
    s = '0;
    s[2*SI] = 1'b1;
    s[SYNC_WIDE_BASE] = 1'b1;
    wr(SYNC_OFF, {8'h0, s});
    #1 chk("sync strobe", {31'h0, sync_out_stb}, 32'h1);
    chk("sync vector", {8'h0, sync_out}, {8'h0, s});
    wr(MODE_A_OFF, 32'h1); wr(MODE_B_OFF, 32'h1);
    wr(LOAD_A_OFF, 32'h800); wr(LOAD_B_OFF, 32'h800); wr(CTL_OFF, 32'h3);
    repeat (100) @(posedge clk);
    pulse_sync(s);
    rd(VAL_A_OFF, va); rd(VAL_B_OFF, vb);
    chk("sync A reloaded", {31'h0, va <= 32'h800 && va >= 32'h7F8}, 32'h1);
    chk("sync B untouched", {31'h0, vb < 32'h7A0}, 32'h1);
    restart();
    wr(CFG_OFF, 32'h1); wr(MODE_A_OFF, 32'h1); wr(LOAD_B_OFF, 32'h0);
    wr(LOAD_A_OFF, 32'h800); wr(CTL_OFF, 32'h1);
    repeat (100) @(posedge clk);
    s = '0;
    s[2*SI+1] = 1'b1;
    pulse_sync(s);
    rd(VAL_A_OFF, va);
    chk("full B sel ignored", {31'h0, va < 32'h7A0}, 32'h1);
  endtask : t_sync

  // Main sequence
  initial begin
    t_readback();
    t_load_now();
    t_prescale();
    t_match_irq();
    t_pwm();
    t_rtc();
    t_sync();
    give_verdict();
  end
endmodule : tb
